// [core/bale_pkg.sv]
// bale_pkg: constants, encodings and carriers of the bit accumulator logic engine
//
// Behaviour
// RULE_01: program identifier command accepts only 256 through 511 as a valid identifier.
// RULE_02: mode call takes signed code 1..5 selecting one of five built-in modes.
// RULE_03: idle instruction changes nothing and just moves to the next command.
// RULE_04: program author places idle instructions to blank or reserve command slots.
// RULE_05: constant load writes its 0 or 1 operand straight into the accumulator.
// RULE_06: main bit load reads register 0..1399, bit 0..15, into the accumulator.
// RULE_07: scratch bit load reads register 0..299, bit 0..15, into the accumulator.
// RULE_08: retained bit load reads register 0..63, bit 0..15, into the accumulator.
// RULE_09: inverted load in every space writes the complement of the addressed bit.
// RULE_10: conjoin in every space gives one only when accumulator and bit are one.
// RULE_11: inverse conjoin gives one only when accumulator is one and bit is zero.
// RULE_12: conjoin results overwrite the accumulator; the source bit is never written.
// RULE_13: commands run strictly in order; each finishes before the next is taken.
// RULE_14: out-of-range operands raise an error and no register access happens.
package bale_pkg;

  // ----------------------------------------------------------------------------
  // operand limits
  // ----------------------------------------------------------------------------
  localparam logic [15:0] BALE_ID_MIN = 16'h0100;
  localparam logic [15:0] BALE_ID_MAX = 16'h01FF;
  localparam logic signed [15:0] BALE_MODE_MIN = 16'sh0001;
  localparam logic signed [15:0] BALE_MODE_MAX = 16'sh0005;
  localparam logic [15:0] BALE_MAIN_MAX = 16'h0577;
  localparam logic [15:0] BALE_SCRATCH_MAX = 16'h012B;
  localparam logic [15:0] BALE_RETAINED_MAX = 16'h003F;
  localparam logic [15:0] BALE_BIT_MAX = 16'h000F;
  localparam logic [15:0] BALE_BOOL_MAX = 16'h0001;
  localparam logic BALE_ACC_RESET = 1'b0;
  localparam logic [15:0] BALE_ID_RESET = 16'h0000;

  // ----------------------------------------------------------------------------
  // command, space, mode and error encodings
  // ----------------------------------------------------------------------------
  typedef enum logic [4:0] {
    BALE_OP_IDLE_INSTRUCTION,
    BALE_OP_PROGRAM_IDENTIFIER_CMD,
    BALE_OP_BUILTIN_MODE_CALL_CMD,
    BALE_OP_CONSTANT_LOAD_CMD,
    BALE_OP_MAIN_BIT_FETCH_CMD,
    BALE_OP_SCRATCH_BIT_FETCH_CMD,
    BALE_OP_RETAINED_BIT_FETCH_CMD,
    BALE_OP_MAIN_BIT_INVERTED_FETCH_CMD,
    BALE_OP_SCRATCH_BIT_INVERTED_FETCH_CMD,
    BALE_OP_RETAINED_BIT_INVERTED_FETCH_CMD,
    BALE_OP_MAIN_BIT_CONJOIN_CMD,
    BALE_OP_SCRATCH_BIT_CONJOIN_CMD,
    BALE_OP_RETAINED_BIT_CONJOIN_CMD,
    BALE_OP_MAIN_BIT_INVERSE_CONJOIN_CMD,
    BALE_OP_SCRATCH_BIT_INVERSE_CONJOIN_CMD,
    BALE_OP_RETAINED_BIT_INVERSE_CONJOIN_CMD
  } bale_op_t;

  typedef enum logic [1:0] {
    BALE_SPACE_MAIN,
    BALE_SPACE_SCRATCH,
    BALE_SPACE_RETAINED
  } bale_space_t;

  typedef enum logic [1:0] {
    BALE_FN_LOAD,
    BALE_FN_LOAD_NOT,
    BALE_FN_AND,
    BALE_FN_AND_NOT
  } bale_fn_t;

  typedef enum logic [2:0] {
    BALE_MODE_NONE,
    BALE_MODE_OVERLOAD,
    BALE_MODE_INDEPENDENT,
    BALE_MODE_REVERSER,
    BALE_MODE_TWO_STEP,
    BALE_MODE_TWO_SPEED
  } bale_mode_t;

  typedef enum logic [2:0] {
    BALE_ERR_NONE,
    BALE_ERR_BAD_OPCODE,
    BALE_ERR_ID_RANGE,
    BALE_ERR_MODE_RANGE,
    BALE_ERR_CONST_RANGE,
    BALE_ERR_INDEX_RANGE,
    BALE_ERR_BIT_RANGE
  } bale_err_t;

  // ----------------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    bale_op_t op;
    logic [15:0] arg1; // identifier, mode code, constant or register index
    logic [15:0] arg2; // bit index
  } bale_instr_t;

  typedef struct packed {
    bale_space_t space;
    logic [15:0] index;
  } bale_rd_t;

endpackage : bale_pkg

// [core/bale_engine.sv]
// bale_engine: sequential decoder and 1-bit accumulator of the custom logic engine
`timescale 1ns/100ps
`default_nettype none

module bale_engine
  import bale_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire bale_instr_t instr,
  output logic rd_valid,
  output bale_rd_t rd_q,
  input wire logic rd_ack,
  input wire logic [15:0] rd_data,
  output logic acc_q,
  output logic [15:0] prog_id_q,
  output logic prog_id_valid_q,
  output logic mode_call_q,
  output bale_mode_t mode_q,
  output logic err_q,
  output bale_err_t err_cause_q,
  output logic retire_q
);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------

  // highest legal register index of a space
  function automatic logic [15:0] bale_space_max(input bale_space_t sp);
    case (sp)
      BALE_SPACE_MAIN: bale_space_max = BALE_MAIN_MAX;
      BALE_SPACE_SCRATCH: bale_space_max = BALE_SCRATCH_MAX;
      default: bale_space_max = BALE_RETAINED_MAX;
    endcase
  endfunction : bale_space_max

  // the four bit-function groups share one layout: function major, space minor
  function automatic logic bale_is_bit_op(input bale_op_t op);
    bale_is_bit_op = (op >= BALE_OP_MAIN_BIT_FETCH_CMD) && (op <= BALE_OP_RETAINED_BIT_INVERSE_CONJOIN_CMD);
  endfunction : bale_is_bit_op

  function automatic logic [3:0] bale_bit_slot(input bale_op_t op);
    logic [4:0] rel;
    rel = 5'(op) - 5'(BALE_OP_MAIN_BIT_FETCH_CMD);
    bale_bit_slot = rel[3:0];
  endfunction : bale_bit_slot

  function automatic bale_space_t bale_op_space(input bale_op_t op);
    logic [3:0] s;
    s = bale_bit_slot(op);
    case (s)
      4'h0, 4'h3, 4'h6, 4'h9: bale_op_space = BALE_SPACE_MAIN;
      4'h1, 4'h4, 4'h7, 4'hA: bale_op_space = BALE_SPACE_SCRATCH;
      default: bale_op_space = BALE_SPACE_RETAINED;
    endcase
  endfunction : bale_op_space

  function automatic bale_fn_t bale_op_fn(input bale_op_t op);
    logic [3:0] s;
    s = bale_bit_slot(op);
    if (s < 4'h3) begin
      bale_op_fn = BALE_FN_LOAD;
    end else if (s < 4'h6) begin
      bale_op_fn = BALE_FN_LOAD_NOT;
    end else if (s < 4'h9) begin
      bale_op_fn = BALE_FN_AND;
    end else begin
      bale_op_fn = BALE_FN_AND_NOT;
    end
  endfunction : bale_op_fn

  // accumulator result of a bit function
  function automatic logic bale_apply(input bale_fn_t fn, input logic acc, input logic b);
    case (fn)
      BALE_FN_LOAD: bale_apply = b;
      BALE_FN_LOAD_NOT: bale_apply = ~b;
      BALE_FN_AND: bale_apply = acc & b;
      default: bale_apply = acc & ~b;
    endcase
  endfunction : bale_apply

  // ----------------------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------------------
  typedef enum logic {
    BALE_ST_READY,
    BALE_ST_READ
  } bale_state_t;

  bale_state_t state_q;
  bale_fn_t fn_q;
  logic [3:0] bit_q;
  logic take;
  logic bit_op;
  bale_space_t op_space;
  logic index_ok;
  logic bit_ok;
  logic signed [15:0] mode_code;
  logic read_done;
  bale_err_t dec_err;

  // only one command in flight: a new one is taken only when the last has finished
  assign instr_ready = (state_q == BALE_ST_READY); // RULE_13
  assign take = instr_valid && instr_ready;
  assign read_done = (state_q == BALE_ST_READ) && rd_ack;
  assign rd_valid = (state_q == BALE_ST_READ);

  // operand decode of the offered command
  assign bit_op = bale_is_bit_op(instr.op);
  assign op_space = bale_op_space(instr.op);
  assign index_ok = instr.arg1 <= bale_space_max(op_space); // RULE_06 RULE_07 RULE_08
  assign bit_ok = instr.arg2 <= BALE_BIT_MAX;
  assign mode_code = $signed(instr.arg1);

  // error classification; any error blocks the register access
  always_comb begin
    dec_err = BALE_ERR_NONE;
    case (instr.op)
      BALE_OP_IDLE_INSTRUCTION: dec_err = BALE_ERR_NONE; // RULE_03
      BALE_OP_PROGRAM_IDENTIFIER_CMD: begin
        if (instr.arg1 < BALE_ID_MIN || instr.arg1 > BALE_ID_MAX) begin
          dec_err = BALE_ERR_ID_RANGE; // RULE_01 RULE_14
        end
      end
      BALE_OP_BUILTIN_MODE_CALL_CMD: begin
        if (mode_code < BALE_MODE_MIN || mode_code > BALE_MODE_MAX) begin
          dec_err = BALE_ERR_MODE_RANGE; // RULE_02 RULE_14
        end
      end
      BALE_OP_CONSTANT_LOAD_CMD: begin
        if (instr.arg1 > BALE_BOOL_MAX) begin
          dec_err = BALE_ERR_CONST_RANGE; // RULE_14
        end
      end
      default: begin
        if (!bit_op) begin
          dec_err = BALE_ERR_BAD_OPCODE;
        end else if (!index_ok) begin
          dec_err = BALE_ERR_INDEX_RANGE; // RULE_14
        end else if (!bit_ok) begin
          dec_err = BALE_ERR_BIT_RANGE; // RULE_14
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // command sequencer and register read request
  // ----------------------------------------------------------------------------

  // a legal bit command holds a read request until the register space answers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= BALE_ST_READY;
      rd_q <= '{space: BALE_SPACE_MAIN, index: 16'h0000};
      fn_q <= BALE_FN_LOAD;
      bit_q <= 4'h0;
    end else if (take && bit_op && dec_err == BALE_ERR_NONE) begin
      state_q <= BALE_ST_READ; // RULE_13
      rd_q <= '{space: op_space, index: instr.arg1};
      fn_q <= bale_op_fn(instr.op);
      bit_q <= instr.arg2[3:0];
    end else if (read_done) begin
      state_q <= BALE_ST_READY;
    end
  end

  // ----------------------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------------------

  // only the accumulator is written; the source register is read and never written
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= BALE_ACC_RESET;
    end else if (take && instr.op == BALE_OP_CONSTANT_LOAD_CMD && dec_err == BALE_ERR_NONE) begin
      acc_q <= instr.arg1[0]; // RULE_05
    end else if (read_done) begin
      acc_q <= bale_apply(fn_q, acc_q, rd_data[bit_q]); // RULE_06 RULE_09 RULE_10 RULE_11 RULE_12
    end
  end

  // ----------------------------------------------------------------------------
  // program identifier
  // ----------------------------------------------------------------------------

  // the last valid identifier is kept; a bad one leaves the old value standing
  always_ff @(posedge clock) begin
    if (srst) begin
      prog_id_q <= BALE_ID_RESET;
      prog_id_valid_q <= 1'b0;
    end else if (take && instr.op == BALE_OP_PROGRAM_IDENTIFIER_CMD && dec_err == BALE_ERR_NONE) begin
      prog_id_q <= instr.arg1; // RULE_01
      prog_id_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // built-in mode call
  // ----------------------------------------------------------------------------

  // one-cycle call pulse; the selected mode stays until the next call
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_call_q <= 1'b0;
      mode_q <= BALE_MODE_NONE;
    end else begin
      mode_call_q <= 1'b0;
      if (take && instr.op == BALE_OP_BUILTIN_MODE_CALL_CMD && dec_err == BALE_ERR_NONE) begin
        mode_call_q <= 1'b1;
        mode_q <= bale_mode_t'(instr.arg1[2:0]); // RULE_02
      end
    end
  end

  // ----------------------------------------------------------------------------
  // completion and error reporting
  // ----------------------------------------------------------------------------

  // retire pulses once per command; error pulses with it, cause held until next error
  always_ff @(posedge clock) begin
    if (srst) begin
      retire_q <= 1'b0;
      err_q <= 1'b0;
      err_cause_q <= BALE_ERR_NONE;
    end else begin
      retire_q <= read_done || (take && !(bit_op && dec_err == BALE_ERR_NONE)); // RULE_03 RULE_13
      err_q <= take && dec_err != BALE_ERR_NONE; // RULE_14
      if (take && dec_err != BALE_ERR_NONE) begin
        err_cause_q <= dec_err;
      end
    end
  end

endmodule : bale_engine

`default_nettype wire

// [verif/bale_checker.sv]
// bale_checker: concurrent checks on the engine ports
`timescale 1ns/100ps
`default_nettype none

module bale_checker
  import bale_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire bale_instr_t instr,
  input wire logic rd_valid,
  input wire bale_rd_t rd_q,
  input wire logic rd_ack,
  input wire logic acc_q,
  input wire logic [15:0] prog_id_q,
  input wire logic prog_id_valid_q,
  input wire logic mode_call_q,
  input wire bale_mode_t mode_q,
  input wire logic err_q,
  input wire bale_err_t err_cause_q,
  input wire logic retire_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // command taken at this edge
  logic take;
  assign take = instr_valid && instr_ready;

  // ----
  // properties
  // ----
  a_read_stands: assert property (rd_valid && !rd_ack |=> rd_valid && $stable(rd_q))
    else $error("read request dropped early");
  a_busy_blocks: assert property (rd_valid |-> !instr_ready && !retire_q && !err_q)
    else $error("command accepted during a read");
  a_ack_retires: assert property (rd_valid && rd_ack |=> retire_q && !rd_valid && instr_ready)
    else $error("bit command did not finish after answer");
  a_idle_keeps: assert property (take && instr.op == BALE_OP_IDLE_INSTRUCTION |=>
    retire_q && !err_q && $stable(acc_q)) else $error("idle changed state");
  a_const_load: assert property (take && instr.op == BALE_OP_CONSTANT_LOAD_CMD && instr.arg1 <= BALE_BOOL_MAX
    |=> retire_q && acc_q == $past(instr.arg1[0])) else $error("constant not loaded");
  a_id_keep: assert property (take && instr.op == BALE_OP_PROGRAM_IDENTIFIER_CMD &&
    instr.arg1 inside {[BALE_ID_MIN:BALE_ID_MAX]} |=> prog_id_valid_q && prog_id_q == $past(instr.arg1))
    else $error("valid identifier not kept");
  a_id_refuse: assert property (take && instr.op == BALE_OP_PROGRAM_IDENTIFIER_CMD &&
    !(instr.arg1 inside {[BALE_ID_MIN:BALE_ID_MAX]}) |=> err_q && err_cause_q == BALE_ERR_ID_RANGE && $stable(prog_id_q))
    else $error("bad identifier not refused");
  a_mode_call: assert property (take && instr.op == BALE_OP_BUILTIN_MODE_CALL_CMD &&
    $signed(instr.arg1) inside {[BALE_MODE_MIN:BALE_MODE_MAX]} |=> mode_call_q && mode_q == $past(instr.arg1[2:0]))
    else $error("mode call not made");
  a_err_no_read: assert property (err_q |-> retire_q && !rd_valid)
    else $error("error without retire or with read");
  a_index_bound: assert property (take && instr.op == BALE_OP_SCRATCH_BIT_FETCH_CMD && instr.arg1 > BALE_SCRATCH_MAX
    |=> err_q && !rd_valid) else $error("bad index reached the read port");

  // main scenarios seen
  c_bit_read: cover property (rd_valid && rd_ack);
  c_error: cover property (err_q);
  c_mode: cover property (mode_call_q);
endmodule : bale_checker

bind bale_engine bale_checker u_chk (.clock(clock), .srst(srst), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .instr(instr), .rd_valid(rd_valid), .rd_q(rd_q), .rd_ack(rd_ack),
  .acc_q(acc_q), .prog_id_q(prog_id_q), .prog_id_valid_q(prog_id_valid_q), .mode_call_q(mode_call_q),
  .mode_q(mode_q), .err_q(err_q), .err_cause_q(err_cause_q), .retire_q(retire_q));

`default_nettype wire

// [verif/testbench.sv]
// testbench: directed scenarios for the bit accumulator logic engine
`timescale 1ns/100ps
`default_nettype none

module testbench
  import bale_pkg::*;
;
  logic clock = 0, srst = 1, instr_valid = 0, rd_ack = 0, got_rd = 0;
  logic [15:0] rd_data = 16'h0000;
  bale_instr_t instr = '0;
  logic instr_ready, rd_valid, acc_q, prog_id_valid_q, mode_call_q, err_q, retire_q;
  logic [15:0] prog_id_q;
  bale_rd_t rd_q, seen_rd;
  bale_mode_t mode_q;
  bale_err_t err_cause_q;
  int n_mismatch = 0, comparisons = 0, cycles = 0;

  bale_engine uut (.clock(clock), .srst(srst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr(instr), .rd_valid(rd_valid), .rd_q(rd_q), .rd_ack(rd_ack), .rd_data(rd_data), .acc_q(acc_q),
    .prog_id_q(prog_id_q), .prog_id_valid_q(prog_id_valid_q), .mode_call_q(mode_call_q), .mode_q(mode_q),
    .err_q(err_q), .err_cause_q(err_cause_q), .retire_q(retire_q));

  // clock source
  initial forever #50 clock = ~clock;

  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  // ----
  // shared tasks
  // ----
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one command; answers its read after stall cycles, far side shows junk otherwise
  task automatic run(input logic [4:0] op, input logic [15:0] a1 = 16'h0000, a2 = 16'h0000,
                     d = 16'h0000, input int stall = 0);
    @(negedge clock);
    instr_valid = 1;
    instr = '{bale_op_t'(op), a1, a2};
    @(negedge clock);
    instr_valid = 0;
    got_rd = 0;
    repeat (20) begin
      rd_ack = rd_valid && !retire_q && stall == 0;
      rd_data = rd_ack ? d : ~d;
      if (retire_q) break;
      if (rd_valid) begin
        got_rd = 1;
        seen_rd = rd_q;
        stall--;
      end
      @(negedge clock);
    end
    chk("retire", 1, retire_q);
  endtask : run

  // ----
  // scenarios
  // ----
  task automatic t_prog;
    run(1, 16'h0100);
    chk("prog_id", 16'h0100, prog_id_q);
    chk("id_valid", 1, prog_id_valid_q);
    run(1, 16'h01FF);
    chk("prog_id", 16'h01FF, prog_id_q);
    run(1, 16'h0200);
    chk("err_cause", BALE_ERR_ID_RANGE, err_cause_q);
    chk("err", 1, err_q);
    run(1, 16'h00FF);
    chk("prog_id", 16'h01FF, prog_id_q);
    for (int m = 1; m <= 5; m++) begin
      run(2, m[15:0]);
      chk("mode", m[15:0], mode_q);
      chk("mode_call", 1, mode_call_q);
    end
    run(2, 16'h0006);
    chk("err", 1, err_q);
    chk("mode_call", 0, mode_call_q);
    run(2, 16'hFFFF);
    chk("err_cause", BALE_ERR_MODE_RANGE, err_cause_q);
    chk("mode", 5, mode_q);
  endtask : t_prog

  // mid-run reset returns identifier, its valid flag, mode, error cause and ready to their idle values
  task automatic t_reset;
    srst = 1;
    @(negedge clock);
    srst = 0;
    chk("id_valid", 0, prog_id_valid_q);
    chk("prog_id", BALE_ID_RESET, prog_id_q);
    chk("mode", BALE_MODE_NONE, mode_q);
    chk("err_cause", BALE_ERR_NONE, err_cause_q);
    chk("ready", 1, instr_ready);
  endtask : t_reset

  task automatic t_const;
    run(3, 16'h0001);
    chk("acc", 1, acc_q);
    run(0);
    chk("acc", 1, acc_q);
    run(3, 16'h0000);
    chk("acc", 0, acc_q);
    run(3, 16'h0002);
    chk("err_cause", BALE_ERR_CONST_RANGE, err_cause_q);
    run(5'h10);
    chk("err_cause", BALE_ERR_BAD_OPCODE, err_cause_q);
    chk("err", 1, err_q);
  endtask : t_const

  // top index and top bit of each space, plain load read answered 0, 1 and 2 cycles late
  task automatic t_fetch;
    logic [15:0] top [3] = '{BALE_MAIN_MAX, BALE_SCRATCH_MAX, BALE_RETAINED_MAX};
    for (int s = 0; s < 3; s++) begin
      run(4 + s, top[s], 16'h000F, 16'h8000, s);
      chk("rd_space", s[15:0], seen_rd.space);
      chk("rd_index", top[s], seen_rd.index);
      chk("acc", 1, acc_q);
      run(7 + s, top[s], 16'h000F, 16'h8000);
      chk("acc", 0, acc_q);
      run(4 + s, top[s] + 16'h0001);
      chk("err_cause", BALE_ERR_INDEX_RANGE, err_cause_q);
      chk("read", 0, got_rd);
    end
  endtask : t_fetch

  task automatic t_conj;
    for (int s = 0; s < 3; s++) begin
      run(3, 16'h0001);
      run(10 + s, 16'h0000, 16'h0000, 16'h0001, 3);
      chk("acc", 1, acc_q);
      run(13 + s, 16'h0000, 16'h0000, 16'hFFFE);
      chk("acc", 1, acc_q);
      run(13 + s, 16'h0000, 16'h0000, 16'h0001);
      chk("acc", 0, acc_q);
      run(10 + s, 16'h0000, 16'h0000, 16'hFFFF);
      chk("acc", 0, acc_q);
    end
    run(13, 16'h0000, 16'h0010);
    chk("err_cause", BALE_ERR_BIT_RANGE, err_cause_q);
  endtask : t_conj

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    srst = 0;
    t_prog;
    t_reset;
    t_const;
    t_fetch;
    t_conj;
    end_of_test;
  end
endmodule : testbench

`default_nettype wire
